/* liu_cfg_pkg.sv */
// Package for the global, termination and jitter configuration bank.
// Assumes a single 10 MHz clock domain and an Avalon-MM register slave.
`default_nettype none

package liu_cfg_pkg;

  // ==========================================================================
  // Register offsets (byte addresses = 4 x index)
  localparam logic [7:0] IDX_SOFT_RESET = 8'h01;
  localparam logic [7:0] IDX_TERM_CH1   = 8'h02;
  localparam logic [7:0] IDX_JITTER_CH1 = 8'h03;
  localparam logic [7:0] IDX_GLOBAL     = 8'h20;
  localparam logic [7:0] IDX_IRQ_SRC    = 8'h21;
  localparam logic [7:0] IDX_TERM_CH2   = 8'h22;
  localparam logic [7:0] IDX_JITTER_CH2 = 8'h23;
  // Channel 2 registers sit this far above channel 1
  localparam logic [7:0] CH2_STRIDE     = 8'h20;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] GLOBAL_RST = 8'h04;
  localparam logic [7:0] TERM_RST   = 8'h00;
  localparam logic [7:0] JITTER_RST = 8'h20;

  // Writable bits; reserved bits read zero
  localparam logic [7:0] GLOBAL_MASK = 8'hdf;
  localparam logic [7:0] TERM_MASK   = 8'h3f;
  localparam logic [7:0] JITTER_MASK = 8'h3f;

  // ==========================================================================
  // Field positions
  localparam int GC_STD_BIT  = 4;
  localparam int GC_COPY_BIT = 3;
  localparam int GC_IRQD_BIT = 2;

  // Settling time after a line standard change
  localparam int STD_SETTLE_US = 50;
  localparam int CLK_MHZ       = 10;
  localparam int STD_SETTLE_CYC = STD_SETTLE_US * CLK_MHZ;

  typedef enum logic [1:0] {
    TERM_75, TERM_120, TERM_100, TERM_110
  } term_int_t;

  typedef enum logic [1:0] {
    JA_OFF, JA_TX, JA_RX
  } ja_place_t;

  typedef enum logic [1:0] {
    IRQ_OD_LOW, IRQ_PP_LOW, IRQ_PP_HIGH
  } irq_style_t;

  // Decoded per-channel settings for the analog and jitter paths
  typedef struct packed {
    logic       tx_term_ext;
    term_int_t  tx_term;
    logic       rx_term_ext;
    term_int_t  rx_term;
    logic       jitter_limit_mode;
    ja_place_t  ja_place;
    logic [7:0] ja_depth_bits;
    logic       ja_corner_low;
  } chan_cfg_t;

endpackage

`default_nettype wire

/* liu_global_term_jitter_cfg.sv */
// Global, termination and jitter configuration registers of a dual line unit.
// Assumes an Avalon-MM master on clk and a separate interrupt aggregator.
//
// Design decision made here: the Avalon-MM register port.
`default_nettype none

module liu_global_term_jitter_cfg (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [9:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  output logic [1:0]                   avs_response,
  input  wire logic [1:0]              chan_irq,
  input  wire logic                    driver_ready,
  output logic                         irq_pin_o,
  output logic                         irq_pin_oe_n,
  output logic                         soft_reset_pulse,
  output logic                         drivers_hiz,
  output logic                         std_t1,
  output logic [1:0]                   monitor_path_select,
  output logic                         broadcast_en,
  output logic                         std_settling,
  output liu_cfg_pkg::chan_cfg_t       ch1_cfg,
  output liu_cfg_pkg::chan_cfg_t       ch2_cfg
);

  // ==========================================================================
  // Register storage
  logic [7:0] global_config_reg;
  logic [7:0] term_reg [2];
  logic [7:0] jitter_reg [2];
  logic       resp_reg;
  logic [31:0] rdata_reg;
  logic [1:0] irq_sync1_reg;
  logic [1:0] irq_sync2_reg;
  logic       hiz_reg;
  logic [9:0] settle_reg;

  // ==========================================================================
  // Address decode
  wire [7:0] idx        = avs_address[9:2];
  wire       wr_lane0   = avs_write & avs_byteenable[0];
  wire       hit_rst    = (idx == liu_cfg_pkg::IDX_SOFT_RESET);
  wire       hit_glb    = (idx == liu_cfg_pkg::IDX_GLOBAL);
  wire       hit_src    = (idx == liu_cfg_pkg::IDX_IRQ_SRC);
  wire       hit_t1     = (idx == liu_cfg_pkg::IDX_TERM_CH1);
  wire       hit_j1     = (idx == liu_cfg_pkg::IDX_JITTER_CH1);
  wire       hit_t2     = (idx == liu_cfg_pkg::IDX_TERM_CH2);
  wire       hit_j2     = (idx == liu_cfg_pkg::IDX_JITTER_CH2);
  wire       copy_on    = global_config_reg[liu_cfg_pkg::GC_COPY_BIT];
  wire       soft_rst   = avs_write & hit_rst & ~avs_waitrequest;
  wire       std_change = wr_lane0 & hit_glb & ~avs_waitrequest &
                          (avs_writedata[liu_cfg_pkg::GC_STD_BIT] !=
                           global_config_reg[liu_cfg_pkg::GC_STD_BIT]);
  wire [7:0] wbyte      = avs_writedata[7:0];
  wire       do_wr      = wr_lane0 & ~avs_waitrequest;

  // Broadcast copies a write on one channel into the other
  wire term_wr1 = do_wr & (hit_t1 | (hit_t2 & copy_on));
  wire term_wr2 = do_wr & (hit_t2 | (hit_t1 & copy_on));
  wire jit_wr1  = do_wr & (hit_j1 | (hit_j2 & copy_on));
  wire jit_wr2  = do_wr & (hit_j2 | (hit_j1 & copy_on));

  // One cycle of wait per access gives registered read data
  assign avs_waitrequest = (avs_read | avs_write) & ~resp_reg;
  assign avs_response    = 2'h0;
  assign avs_readdata    = rdata_reg;

  // ==========================================================================
  // Read mux
  wire [1:0] irq_src_flags = ~irq_sync2_reg;
  wire [7:0] rd_byte =
    hit_glb ? global_config_reg :
    hit_src ? {6'h00, irq_src_flags} :
    hit_t1  ? term_reg[0] :
    hit_t2  ? term_reg[1] :
    hit_j1  ? jitter_reg[0] :
    hit_j2  ? jitter_reg[1] : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_reg  <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      resp_reg  <= (avs_read | avs_write) & ~resp_reg;
      rdata_reg <= (avs_read & ~resp_reg) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_config_reg <= liu_cfg_pkg::GLOBAL_RST;
    end else if (soft_rst) begin
      // Standard select survives the soft reset
      global_config_reg <= liu_cfg_pkg::GLOBAL_RST |
        {3'h0, global_config_reg[liu_cfg_pkg::GC_STD_BIT], 4'h0};
    end else if (do_wr & hit_glb) begin
      global_config_reg <= wbyte & liu_cfg_pkg::GLOBAL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      term_reg[0]   <= liu_cfg_pkg::TERM_RST;
      term_reg[1]   <= liu_cfg_pkg::TERM_RST;
      jitter_reg[0] <= liu_cfg_pkg::JITTER_RST;
      jitter_reg[1] <= liu_cfg_pkg::JITTER_RST;
    end else if (soft_rst) begin
      term_reg[0]   <= liu_cfg_pkg::TERM_RST;
      term_reg[1]   <= liu_cfg_pkg::TERM_RST;
      jitter_reg[0] <= liu_cfg_pkg::JITTER_RST;
      jitter_reg[1] <= liu_cfg_pkg::JITTER_RST;
    end else begin
      if (term_wr1) term_reg[0] <= wbyte & liu_cfg_pkg::TERM_MASK;
      if (term_wr2) term_reg[1] <= wbyte & liu_cfg_pkg::TERM_MASK;
      if (jit_wr1) jitter_reg[0] <= wbyte & liu_cfg_pkg::JITTER_MASK;
      if (jit_wr2) jitter_reg[1] <= wbyte & liu_cfg_pkg::JITTER_MASK;
    end
  end

  // ==========================================================================
  // Driver high impedance: set by any reset, released when the line side is ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hiz_reg <= 1'b1;
    end else if (soft_rst) begin
      hiz_reg <= 1'b1;
    end else if (driver_ready) begin
      hiz_reg <= 1'b0;
    end
  end
  assign drivers_hiz = hiz_reg;

  // Settling flag only informs software; the host must itself honour the wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg <= 10'h000;
    end else if (std_change) begin
      settle_reg <= 10'(liu_cfg_pkg::STD_SETTLE_CYC);
    end else if (settle_reg != 10'h000) begin
      settle_reg <= settle_reg - 10'h001;
    end
  end
  assign std_settling = (settle_reg != 10'h000);

  // ==========================================================================
  // Interrupt pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sync1_reg <= 2'h0;
      irq_sync2_reg <= 2'h0;
    end else begin
      irq_sync1_reg <= chan_irq;
      irq_sync2_reg <= irq_sync1_reg;
    end
  end

  wire irq_active = (|irq_sync2_reg) & ~global_config_reg[liu_cfg_pkg::GC_IRQD_BIT];
  wire pin_pp     = global_config_reg[0];
  wire pin_high   = global_config_reg[1] & global_config_reg[0];
  // Open drain only pulls low; the enable is active low
  assign irq_pin_o    = pin_pp ? (pin_high ? irq_active : ~irq_active) : 1'b0;
  assign irq_pin_oe_n = pin_pp ? 1'b0 : ~irq_active;

  // ==========================================================================
  // Decoded outputs
  assign soft_reset_pulse    = soft_rst;
  assign std_t1              = global_config_reg[liu_cfg_pkg::GC_STD_BIT];
  assign monitor_path_select = global_config_reg[7:6];
  assign broadcast_en        = copy_on;

  function automatic liu_cfg_pkg::chan_cfg_t decode(input logic [7:0] t, input logic [7:0] j,
                                                    input logic t1);
    liu_cfg_pkg::chan_cfg_t c;
    c.tx_term_ext   = t[5] & ~t1;
    c.tx_term       = liu_cfg_pkg::term_int_t'(t[4:3]);
    c.rx_term_ext   = t[2];
    c.rx_term       = liu_cfg_pkg::term_int_t'(t[1:0]);
    c.jitter_limit_mode      = j[5];
    c.ja_place      = (j[3] == 1'b0) ? liu_cfg_pkg::JA_OFF :
                      (j[4] ? liu_cfg_pkg::JA_RX : liu_cfg_pkg::JA_TX);
    c.ja_depth_bits = j[2] ? 8'h20 : (j[1] ? 8'h40 : 8'h80);
    c.ja_corner_low = j[0];
    return c;
  endfunction

  assign ch1_cfg = decode(term_reg[0], jitter_reg[0], std_t1);
  assign ch2_cfg = decode(term_reg[1], jitter_reg[1], std_t1);

  // ==========================================================================
  // Checks
  sequence soft_write_s;
    avs_write && hit_rst && !avs_waitrequest;
  endsequence

  soft_reset_defaults_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_write_s |=> (term_reg[0] == liu_cfg_pkg::TERM_RST &&
                      jitter_reg[1] == liu_cfg_pkg::JITTER_RST))
    else $error("soft reset left a channel register changed");

  soft_reset_reads_a: assert property (@(posedge clk) disable iff (!rst_n)
    (avs_read && hit_rst && !avs_waitrequest) |-> avs_readdata == 32'h0000_0000)
    else $error("soft reset register returned data");

  reset_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_write_s |=> drivers_hiz)
    else $error("drivers not high impedance after reset");

  std_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_write_s |=> std_t1 == $past(std_t1) && global_config_reg[2])
    else $error("soft reset changed the standard bit");

  copy_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (do_wr && hit_t1 && copy_on && !hit_rst) |=> term_reg[1] == term_reg[0])
    else $error("broadcast write not copied");

  no_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    (do_wr && hit_t1 && !copy_on) |=> $stable(term_reg[1]))
    else $error("write copied with broadcast off");

  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    global_config_reg[2] |-> (global_config_reg[0] ? irq_pin_o != global_config_reg[1] :
                              irq_pin_oe_n))
    else $error("interrupt active while globally disabled");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    term_reg[0][7:6] == 2'h0 && jitter_reg[0][7:6] == 2'h0 && !global_config_reg[5])
    else $error("reserved bit set");

  settle_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    std_change |=> std_settling [*8])
    else $error("settling flag dropped early");

  settle_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    std_change |=> settle_reg == 10'(liu_cfg_pkg::STD_SETTLE_CYC))
    else $error("settling count not loaded");

  hiz_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    (driver_ready && !soft_rst) |=> !drivers_hiz)
    else $error("drivers held after the line side was ready");

  // ==========================================================================
  // Bus, global and channel register checks
  sequence glb_write_s;
    do_wr && hit_glb;
  endsequence

  sequence src_read_s;
    avs_read && hit_src && !avs_waitrequest;
  endsequence

  wait_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("more than one wait state");

  readdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (avs_waitrequest || !avs_read) |-> avs_readdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  monitor_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    glb_write_s |=> monitor_path_select == $past(avs_writedata[7:6]))
    else $error("monitor field not taken from the write");

  std_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    glb_write_s |=> std_t1 == $past(avs_writedata[4]))
    else $error("standard bit not taken from the write");

  copy_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    glb_write_s |=> broadcast_en == $past(avs_writedata[3]))
    else $error("broadcast flag not taken from the write");

  irq_disable_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    glb_write_s |=> global_config_reg[2] == $past(avs_writedata[2]))
    else $error("interrupt disable not taken from the write");

  soft_reset_globals_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_write_s |=> (global_config_reg & 8'hef) == liu_cfg_pkg::GLOBAL_RST)
    else $error("soft reset left a global field changed");

  soft_reset_all_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_write_s |=> (term_reg[1] == liu_cfg_pkg::TERM_RST &&
                      jitter_reg[0] == liu_cfg_pkg::JITTER_RST))
    else $error("soft reset left the other registers changed");

  reserved_ch2_a: assert property (@(posedge clk) disable iff (!rst_n)
    term_reg[1][7:6] == 2'h0 && jitter_reg[1][7:6] == 2'h0)
    else $error("channel two reserved bit set");

  irq_src_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    src_read_s |-> avs_readdata == {30'h0, ~$past(irq_sync2_reg)})
    else $error("interrupt source read wrong");

  // ==========================================================================
  // Interrupt pin and decode checks
  pin_od_a: assert property (@(posedge clk) disable iff (!rst_n)
    !global_config_reg[0] |-> !irq_pin_o)
    else $error("open drain pin driven high");

  pin_od_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!global_config_reg[0] && !irq_active) |-> irq_pin_oe_n)
    else $error("open drain pin not released");

  pin_pp_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    global_config_reg[0] |-> !irq_pin_oe_n)
    else $error("push-pull pin not driven");

  pin_pp_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    (global_config_reg[0] && irq_active) |-> irq_pin_o == global_config_reg[1])
    else $error("push-pull pin at wrong active level");

  tx_ext_t1_a: assert property (@(posedge clk) disable iff (!rst_n)
    std_t1 |-> (!ch1_cfg.tx_term_ext && !ch2_cfg.tx_term_ext))
    else $error("external transmit termination in T1 mode");

  tx_ext_e1_a: assert property (@(posedge clk) disable iff (!rst_n)
    !std_t1 |-> ch1_cfg.tx_term_ext == term_reg[0][5])
    else $error("external transmit termination lost in E1 mode");

  tx_term_code_a: assert property (@(posedge clk) disable iff (!rst_n)
    ch1_cfg.tx_term == term_reg[0][4:3])
    else $error("transmit termination code wrong");

  rx_term_a: assert property (@(posedge clk) disable iff (!rst_n)
    {ch2_cfg.rx_term_ext, ch2_cfg.rx_term} == term_reg[1][2:0])
    else $error("receive termination code wrong");

  jitter_limit_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    ch2_cfg.jitter_limit_mode == jitter_reg[1][5])
    else $error("limit mode bit wrong");

  ja_place_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !jitter_reg[0][3] |-> ch1_cfg.ja_place == liu_cfg_pkg::JA_OFF)
    else $error("attenuator not left unused");

  ja_place_tx_a: assert property (@(posedge clk) disable iff (!rst_n)
    jitter_reg[0][4:3] == 2'h1 |-> ch1_cfg.ja_place == liu_cfg_pkg::JA_TX)
    else $error("attenuator not in transmit path");

  ja_place_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
    jitter_reg[1][4:3] == 2'h3 |-> ch2_cfg.ja_place == liu_cfg_pkg::JA_RX)
    else $error("attenuator not in receive path");

  ja_depth_small_a: assert property (@(posedge clk) disable iff (!rst_n)
    jitter_reg[1][2] |-> ch2_cfg.ja_depth_bits == 8'h20)
    else $error("short buffer depth wrong");

  ja_depth_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
    jitter_reg[0][2:1] == 2'h1 |-> ch1_cfg.ja_depth_bits == 8'h40)
    else $error("middle buffer depth wrong");

  ja_depth_full_a: assert property (@(posedge clk) disable iff (!rst_n)
    jitter_reg[0][2:1] == 2'h0 |-> ch1_cfg.ja_depth_bits == 8'h80)
    else $error("full buffer depth wrong");

  ja_corner_a: assert property (@(posedge clk) disable iff (!rst_n)
    ch1_cfg.ja_corner_low == jitter_reg[0][0])
    else $error("transfer corner bit wrong");

endmodule

`default_nettype wire

/* liu_global_term_jitter_cfg_bench.sv */
// Self-checking bench for the global, termination and jitter register bank.
// Assumes an Avalon slave with any number of wait states and the package defaults.
`default_nettype none

module liu_global_term_jitter_cfg_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                   clk;
  logic                   rst_n;
  logic [9:0]             avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic [1:0]             avs_response;
  logic [1:0]             chan_irq;
  logic                   driver_ready;
  logic                   irq_pin_o;
  logic                   irq_pin_oe_n;
  logic                   drivers_hiz;
  logic                   soft_reset_pulse;
  logic                   std_t1;
  logic [1:0]             monitor_path_select;
  logic                   broadcast_en;
  logic                   std_settling;
  liu_cfg_pkg::chan_cfg_t ch1_cfg;
  liu_cfg_pkg::chan_cfg_t ch2_cfg;
  int                     err_count;
  int                     n_tests;
  int                     cyc = 0;
  int                     n_pulse = 0;

  liu_global_term_jitter_cfg u_liu_global_term_jitter_cfg (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .chan_irq(chan_irq), .driver_ready(driver_ready),
    .irq_pin_o(irq_pin_o), .irq_pin_oe_n(irq_pin_oe_n), .soft_reset_pulse(soft_reset_pulse),
    .drivers_hiz(drivers_hiz), .std_t1(std_t1), .monitor_path_select(monitor_path_select),
    .broadcast_en(broadcast_en), .std_settling(std_settling), .ch1_cfg(ch1_cfg),
    .ch2_cfg(ch2_cfg));

  // ==========================================================================
  // Clock, reset, timeout
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Ceiling well above the roughly 620 cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // Counts soft reset writes as the design reports them
  always @(posedge clk) begin
    if (soft_reset_pulse === 1'b1) n_pulse <= n_pulse + 1;
  end

  // ==========================================================================
  // Reporting and bus tasks
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until the edge that samples waitrequest low; data taken there
  task automatic bus(input logic is_wr, input logic [9:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= is_wr;
    avs_read      <= !is_wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    chk("response", 32'h0, {30'h0, avs_response});
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // Outputs are judged once the completing edge has settled
    @(negedge clk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, exp}, q);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic reset_values();
    chk("hiz", 32'h1, {31'h0, drivers_hiz});
    rd("global", 10'h080, liu_cfg_pkg::GLOBAL_RST);
    rd("term1", 10'h008, liu_cfg_pkg::TERM_RST);
    rd("jit2", 10'h08c, liu_cfg_pkg::JITTER_RST);
    rd("irqsrc", 10'h084, 8'h03);
    rd("unmapped", 10'h3fc, 8'h00);
    chk("depth", 32'd128, {24'h0, ch1_cfg.ja_depth_bits});
    @(posedge clk);
    driver_ready <= 1'b1;
    repeat (3) @(negedge clk);
    chk("hiz off", 32'h0, {31'h0, drivers_hiz});
  endtask

  task automatic decode_e1();
    wr(10'h008, 8'h22);
    chk("tx ext", 32'h1, {31'h0, ch1_cfg.tx_term_ext});
    chk("rx term", liu_cfg_pkg::TERM_100, {30'h0, ch1_cfg.rx_term});
    wr(10'h00c, 8'h1b);
    chk("limit", 32'h0, {31'h0, ch1_cfg.jitter_limit_mode});
    chk("place rx", liu_cfg_pkg::JA_RX, {30'h0, ch1_cfg.ja_place});
    chk("depth64", 32'd64, {24'h0, ch1_cfg.ja_depth_bits});
    chk("corner", 32'h1, {31'h0, ch1_cfg.ja_corner_low});
    wr(10'h00c, 8'h0d);
    chk("place tx", liu_cfg_pkg::JA_TX, {30'h0, ch1_cfg.ja_place});
    chk("depth32", 32'd32, {24'h0, ch1_cfg.ja_depth_bits});
  endtask

  task automatic go_t1_broadcast();
    wr(10'h080, 8'hdf);
    chk("settling", 32'h1, {31'h0, std_settling});
    // The host must stay off the bus while internal clocking settles
    repeat (liu_cfg_pkg::STD_SETTLE_CYC + 5) @(negedge clk);
    chk("settled", 32'h0, {31'h0, std_settling});
    rd("global rsv", 10'h080, 8'hdf);
    chk("std", 32'h1, {31'h0, std_t1});
    chk("monitor", 32'h3, {30'h0, monitor_path_select});
    chk("tx ext t1", 32'h0, {31'h0, ch1_cfg.tx_term_ext});
    wr(10'h08c, 8'h0b);
    chk("place ch2", liu_cfg_pkg::JA_TX, {30'h0, ch2_cfg.ja_place});
    rd("copy jit1", 10'h00c, 8'h0b);
    wr(10'h088, 8'h3f);
    rd("copy term1", 10'h008, 8'h3f);
    wr(10'h080, 8'h50);
    chk("copy off", 32'h0, {31'h0, broadcast_en});
    chk("mon rx", 32'h1, {30'h0, monitor_path_select});
    wr(10'h008, 8'h09);
    rd("nocopy term2", 10'h088, 8'h3f);
  endtask

  task automatic irq_styles();
    logic [7:0] g[6] = '{8'h11, 8'h13, 8'h12, 8'h15, 8'h17, 8'h14};
    logic       eo[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic       en[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    @(posedge clk);
    chan_irq <= 2'b01;
    repeat (4) @(posedge clk);
    rd("irqsrc ch1", 10'h084, 8'h02);
    for (int i = 0; i < 6; i++) begin
      wr(10'h080, g[i]);
      chk("pin level", {31'h0, eo[i]}, {31'h0, irq_pin_o});
      chk("pin enable", {31'h0, en[i]}, {31'h0, irq_pin_oe_n});
    end
  endtask

  task automatic soft_reset();
    @(posedge clk);
    driver_ready <= 1'b0;
    wr(10'h004, 8'ha5);
    chk("hiz sr", 32'h1, {31'h0, drivers_hiz});
    rd("global sr", 10'h080, 8'h14);
    rd("term1 sr", 10'h008, 8'h00);
    rd("jit1 sr", 10'h00c, 8'h20);
    rd("term2 sr", 10'h088, 8'h00);
    rd("sr reg", 10'h004, 8'h00);
    chk("sr pulse", 32'h1, n_pulse);
  endtask

  initial begin
    rst_n         = 1'b0;
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = '0;
    chan_irq      = 2'b00;
    driver_ready  = 1'b0;
    err_count     = 0;
    n_tests       = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    reset_values();
    decode_e1();
    go_t1_broadcast();
    irq_styles();
    soft_reset();
    report_and_stop();
  end

endmodule

`default_nettype wire
